// *** hdl/fsl_regs.vh ***
// Constants for the security register, parameter table and block lock command handler
// Summary of operation
// - Table read 5Ah: address, eight dummies, data
// - Table address upper sixteen bits zero; byte index
// - Security erase 44h needs write enable latch
// - Register select by address bits 15..8
// - Erase discarded unless select rises after byte
// - Busy high during erase, low after
// - Erase completion clears write enable latch
// - Locked security register ignores erase and program
// - Program 42h, 1..256 bytes, needs latch
// - Read 48h, eight dummies, MSB first out
// - Read address wraps within the register
// - Read ignored while a cycle runs
// - Nonzero upper address reads undefined data
// - Lock bits protect only when select set
// - Lock bits volatile, reset to one
// - Opcode 36h sets addressed lock bit
// - Opcode 39h clears addressed lock bit
// - Opcode 3Dh returns lock bit in LSB
`ifndef FSL_REGS_VH
`define FSL_REGS_VH

`define FSL_OP_TABLE_RD    8'h5a
`define FSL_OP_SEC_ERASE   8'h44
`define FSL_OP_SEC_PROG    8'h42
`define FSL_OP_SEC_RD      8'h48
`define FSL_OP_LOCK_SET    8'h36
`define FSL_OP_LOCK_CLR    8'h39
`define FSL_OP_LOCK_RD     8'h3d

`define FSL_SEL1           8'h10
`define FSL_SEL2           8'h20
`define FSL_SEL3           8'h30
`define FSL_SEL_BAD        2'h3

`define FSL_CNT_OPC_END    6'h07
`define FSL_CNT_ADR_END    6'h1f
`define FSL_CNT_ADR_DONE   6'h20
`define FSL_CNT_DUMMY_DONE 6'h28
`define FSL_CNT_MAX        6'h3f
`define FSL_CNT_REWIND     6'h38

`define FSL_LOCK_HI        23
`define FSL_LOCK_LO        18
`define FSL_LOCK_N         64
`define FSL_LOCK_RESET     64'hffffffffffffffff
`define FSL_ERASED         8'hff
`define FSL_PTR_LAST       8'hff

`define FSL_CLK_MHZ        100
`define FSL_T_SE_US        1000
`define FSL_T_PP_US        500
`define FSL_BUF_W          18

`endif

// *** hdl/fsl_buf.v ***
// Two entry valid/ready buffer for program bytes
`timescale 1ns/1ps
module fsl_buf #(
	parameter W = 18
) (
	// Clock and reset
	input  wire         mclk,
	input  wire         rst_b,
	// Fill side
	input  wire         in_valid,
	output wire         in_ready,
	input  wire [W-1:0] in_data,
	// Drain side
	output wire         out_valid,
	input  wire         out_ready,
	output wire [W-1:0] out_data
);

reg [W-1:0] slot0;
reg [W-1:0] slot1;
reg [1:0]   fill;

assign in_ready  = (fill != 2'h2);
assign out_valid = (fill != 2'h0);
assign out_data  = slot0;

wire push = in_valid & in_ready;
wire pop  = out_valid & out_ready;

always @(posedge mclk or negedge rst_b) begin
	if (!rst_b) begin
		slot0 <= {W{1'b0}};
		slot1 <= {W{1'b0}};
		fill  <= 2'h0;
	end else begin
		// Slot 0 is always the head
		if (pop) begin
			slot0 <= (fill == 2'h2) ? slot1 : in_data;
		end else if (push && fill == 2'h0) begin
			slot0 <= in_data;
		end
		if (push && (fill == 2'h2 || (fill == 2'h1 && !pop))) begin
			slot1 <= in_data;
		end
		fill <= fill + {1'b0, push} - {1'b0, pop};
	end
end

endmodule // fsl_buf

// *** hdl/fsl_cmd.v ***
// Serial command handler: parameter table, security registers, block locks
`timescale 1ns/1ps
`include "fsl_regs.vh"
module fsl_cmd #(
	parameter [23:0] ERASE_CYCLES = `FSL_T_SE_US * `FSL_CLK_MHZ,
	parameter [23:0] PROG_CYCLES  = `FSL_T_PP_US * `FSL_CLK_MHZ
) (
	// Clock and reset
	input  wire        mclk,
	input  wire        rst_b,
	// Serial link pins
	input  wire        spi_clk,
	input  wire        chip_sel_b,
	input  wire        serial_in_line,
	output reg         serial_out,
	output reg         serial_out_en,
	// Status bits
	input  wire        wel_set,
	input  wire [2:0]  secreg_otp_lock_bits,
	input  wire        write_protect_select,
	output reg         write_enable_latch,
	output reg         busy,
	// Array protection query
	input  wire [23:0] prot_addr,
	input  wire        legacy_range_protect,
	output reg         array_protected
);

////////////////////////////////////////////////////////////////////////
// Functions

function [1:0] sec_idx;
	input [7:0] a;
	begin
		case (a)
			`FSL_SEL1: sec_idx = 2'h0;
			`FSL_SEL2: sec_idx = 2'h1;
			`FSL_SEL3: sec_idx = 2'h2;
			default:   sec_idx = `FSL_SEL_BAD;
		endcase
	end
endfunction

// Small fixed table; unlisted bytes read as ones
function [7:0] table_byte;
	input [7:0] a;
	begin
		case (a)
			8'h00:   table_byte = 8'h53;
			8'h01:   table_byte = 8'h46;
			8'h02:   table_byte = 8'h44;
			8'h03:   table_byte = 8'h50;
			8'h04:   table_byte = 8'h00;
			8'h05:   table_byte = 8'h01;
			default: table_byte = 8'hff;
		endcase
	end
endfunction

////////////////////////////////////////////////////////////////////////
// Pin synchronisers

reg clk_s1;
reg clk_s2;
reg clk_s3;
reg cs_s1;
reg cs_s2;
reg cs_s3;
reg si_s1;
reg si_s2;

always @(posedge mclk or negedge rst_b) begin
	if (!rst_b) begin
		clk_s1 <= 1'b0;
		clk_s2 <= 1'b0;
		clk_s3 <= 1'b0;
		cs_s1  <= 1'b1;
		cs_s2  <= 1'b1;
		cs_s3  <= 1'b1;
		si_s1  <= 1'b0;
		si_s2  <= 1'b0;
	end else begin
		clk_s1 <= spi_clk;
		clk_s2 <= clk_s1;
		clk_s3 <= clk_s2;
		cs_s1  <= chip_sel_b;
		cs_s2  <= cs_s1;
		cs_s3  <= cs_s2;
		si_s1  <= serial_in_line;
		si_s2  <= si_s1;
	end
end

wire rise  = clk_s2 & ~clk_s3 & ~cs_s2;
wire fall  = ~clk_s2 & clk_s3 & ~cs_s2;
wire cs_up = cs_s2 & ~cs_s3;

////////////////////////////////////////////////////////////////////////
// Command shifter

localparam ST_IDLE  = 2'h0;
localparam ST_FILL  = 2'h1;
localparam ST_WAIT  = 2'h2;
localparam ST_PROG  = 2'h3;

reg  [1:0]  state;
reg  [5:0]  cnt;
reg  [7:0]  opcode;
reg  [23:0] addr;
reg  [7:0]  inb;
reg  [7:0]  rd_ptr;
reg  [7:0]  wr_ptr;
reg  [1:0]  prog_idx;
reg         prog_ok;
reg         rd_ign;
reg  [7:0]  out_sh;

wire [23:0] next_addr = {addr[22:0], si_s2};
wire [7:0]  next_byte = {inb[6:0], si_s2};
wire [1:0]  nidx      = sec_idx(next_addr[15:8]);
wire [1:0]  aidx      = sec_idx(addr[15:8]);
wire        lock_n    = (nidx != `FSL_SEL_BAD) && secreg_otp_lock_bits[nidx];
wire        lock_a    = (aidx != `FSL_SEL_BAD) && secreg_otp_lock_bits[aidx];
wire        byte_done = rise && cnt >= `FSL_CNT_ADR_DONE && cnt[2:0] == 3'h7;

// Programming buffer
wire        buf_in_ready;
wire        buf_out_valid;
wire [17:0] buf_out_data;
wire        drain_ready = (state != ST_FILL);
wire        push = byte_done && prog_ok;

fsl_buf #(.W(`FSL_BUF_W)) u_buf (
	.mclk      (mclk),
	.rst_b     (rst_b),
	.in_valid  (push),
	.in_ready  (buf_in_ready),
	.in_data   ({prog_idx, wr_ptr, next_byte}),
	.out_valid (buf_out_valid),
	.out_ready (drain_ready),
	.out_data  (buf_out_data)
);

always @(posedge mclk or negedge rst_b) begin
	if (!rst_b) begin
		cnt      <= 6'h00;
		opcode   <= 8'h00;
		addr     <= 24'h000000;
		inb      <= 8'h00;
		rd_ptr   <= 8'h00;
		wr_ptr   <= 8'h00;
		prog_idx <= 2'h0;
		prog_ok  <= 1'b0;
		rd_ign   <= 1'b0;
	end else if (cs_s2) begin
		cnt <= 6'h00;
		if (cs_up) begin
			prog_ok <= 1'b0;
		end
	end else if (rise) begin
		// Rewind from 3Fh to 38h past the dummies but keep the bit phase
		cnt <= (cnt == `FSL_CNT_MAX) ? `FSL_CNT_REWIND : cnt + 6'h01;
		inb <= next_byte;
		if (cnt <= `FSL_CNT_OPC_END) begin
			opcode <= {opcode[6:0], si_s2};
		end else if (cnt <= `FSL_CNT_ADR_END) begin
			addr <= next_addr;
		end
		if (cnt == `FSL_CNT_OPC_END) begin
			rd_ign <= busy;
		end
		if (cnt == `FSL_CNT_ADR_END) begin
			rd_ptr   <= next_addr[7:0];
			wr_ptr   <= next_addr[7:0];
			prog_idx <= nidx;
			prog_ok  <= opcode == `FSL_OP_SEC_PROG && write_enable_latch &&
			            nidx != `FSL_SEL_BAD && !lock_n && state == ST_IDLE;
		end
		if (push && buf_in_ready) begin
			wr_ptr <= wr_ptr + 8'h01;
		end
	end else if (fall && serial_out_en && cnt[2:0] == 3'h7) begin
		// Advance on the last bit so the next byte load sees the new pointer
		rd_ptr <= rd_ptr + 8'h01;
	end
end

////////////////////////////////////////////////////////////////////////
// Security register storage

reg  [7:0] sec_mem [0:767];
reg  [7:0] erase_ptr;
reg  [1:0] erase_idx;
reg  [23:0] timer;

wire       mem_we    = (state == ST_FILL) || (buf_out_valid && drain_ready);
wire [9:0] mem_waddr = (state == ST_FILL) ? {erase_idx, erase_ptr} : buf_out_data[17:8];
wire [7:0] old_byte  = sec_mem[buf_out_data[17:8]];
// Programming only clears bits; erase restores ones
wire [7:0] mem_wdata = (state == ST_FILL) ? `FSL_ERASED : (old_byte & buf_out_data[7:0]);

always @(posedge mclk) begin
	if (mem_we) begin
		sec_mem[mem_waddr] <= mem_wdata;
	end
end

////////////////////////////////////////////////////////////////////////
// Self-timed erase and program sequencer

wire erase_go = cs_up && opcode == `FSL_OP_SEC_ERASE && cnt == `FSL_CNT_ADR_DONE &&
                write_enable_latch && aidx != `FSL_SEL_BAD && !lock_a &&
                state == ST_IDLE;
wire prog_go  = cs_up && prog_ok;

reg  [1:0] next_state;
reg        cycle_done;

always @* begin
	next_state = state;
	cycle_done = 1'b0;
	case (state)
		ST_IDLE: begin
			if (erase_go) begin
				next_state = ST_FILL;
			end else if (prog_go) begin
				next_state = ST_PROG;
			end
		end
		ST_FILL: begin
			if (erase_ptr == `FSL_PTR_LAST) begin
				next_state = ST_WAIT;
			end
		end
		ST_WAIT: begin
			if (timer == 24'h000000) begin
				next_state = ST_IDLE;
				cycle_done = 1'b1;
			end
		end
		ST_PROG: begin
			if (timer == 24'h000000 && !buf_out_valid) begin
				next_state = ST_IDLE;
				cycle_done = 1'b1;
			end
		end
		default: begin
			next_state = ST_IDLE;
		end
	endcase
end

always @(posedge mclk or negedge rst_b) begin
	if (!rst_b) begin
		state     <= ST_IDLE;
		erase_ptr <= 8'h00;
		erase_idx <= 2'h0;
		timer     <= 24'h000000;
		busy      <= 1'b0;
	end else begin
		state <= next_state;
		busy  <= (next_state != ST_IDLE);
		if (erase_go) begin
			erase_idx <= aidx;
			erase_ptr <= 8'h00;
			timer     <= ERASE_CYCLES;
		end else if (state == ST_IDLE && prog_go) begin
			timer <= PROG_CYCLES;
		end else if (state == ST_FILL) begin
			erase_ptr <= erase_ptr + 8'h01;
		end else if (timer != 24'h000000 && state != ST_IDLE) begin
			timer <= timer - 24'h000001;
		end
	end
end

////////////////////////////////////////////////////////////////////////
// Write enable latch and block lock bits

reg [`FSL_LOCK_N-1:0] lock_bits;

wire lock_cmd = cs_up && cnt == `FSL_CNT_ADR_DONE && write_enable_latch && !busy &&
                (opcode == `FSL_OP_LOCK_SET || opcode == `FSL_OP_LOCK_CLR);

always @(posedge mclk or negedge rst_b) begin
	if (!rst_b) begin
		write_enable_latch <= 1'b0;
		lock_bits          <= `FSL_LOCK_RESET;
		array_protected    <= 1'b1;
	end else begin
		// Set wins over a same-cycle clear
		if (wel_set) begin
			write_enable_latch <= 1'b1;
		end else if (cycle_done || lock_cmd) begin
			write_enable_latch <= 1'b0;
		end
		if (lock_cmd) begin
			lock_bits[addr[`FSL_LOCK_HI:`FSL_LOCK_LO]] <= (opcode == `FSL_OP_LOCK_SET);
		end
		array_protected <= write_protect_select ?
		                   lock_bits[prot_addr[`FSL_LOCK_HI:`FSL_LOCK_LO]] : legacy_range_protect;
	end
end

////////////////////////////////////////////////////////////////////////
// Read data output, driven on the falling edge of the link clock

reg  [5:0] data_start;
reg        rd_cmd;
reg  [7:0] rd_byte;
wire [1:0] ridx = sec_idx(addr[15:8]);

always @* begin
	data_start = `FSL_CNT_DUMMY_DONE;
	rd_cmd     = 1'b0;
	rd_byte    = `FSL_ERASED;
	case (opcode)
		`FSL_OP_TABLE_RD: begin
			rd_cmd  = 1'b1;
			rd_byte = table_byte(rd_ptr);
		end
		`FSL_OP_SEC_RD: begin
			rd_cmd = !rd_ign;
			// Bad selects read as ones; address bits 23..16 are ignored
			if (ridx != `FSL_SEL_BAD) begin
				rd_byte = sec_mem[{ridx, rd_ptr}];
			end
		end
		`FSL_OP_LOCK_RD: begin
			data_start = `FSL_CNT_ADR_DONE;
			rd_cmd     = 1'b1;
			rd_byte    = {7'h00, lock_bits[addr[`FSL_LOCK_HI:`FSL_LOCK_LO]]};
		end
		default: begin
			rd_cmd = 1'b0;
		end
	endcase
end

always @(posedge mclk or negedge rst_b) begin
	if (!rst_b) begin
		serial_out    <= 1'b0;
		serial_out_en <= 1'b0;
		out_sh        <= 8'h00;
	end else if (cs_s2) begin
		serial_out_en <= 1'b0;
	end else if (fall && rd_cmd && cnt >= data_start) begin
		serial_out_en <= 1'b1;
		if (cnt[2:0] == 3'h0) begin
			serial_out <= rd_byte[7];
			out_sh     <= {rd_byte[6:0], 1'b0};
		end else begin
			serial_out <= out_sh[7];
			out_sh     <= {out_sh[6:0], 1'b0};
		end
	end
end

endmodule // fsl_cmd

// *** verification/fsl_chk.sv ***
// Checker on the command handler's ports
`timescale 1ns/1ps
module fsl_chk #(
	parameter [23:0] ERASE_CYCLES = 24'd20,
	parameter [23:0] PROG_CYCLES  = 24'd10
) (
	// Clock and reset
	input wire        mclk,
	input wire        rst_b,
	// Link
	input wire        spi_clk,
	input wire        chip_sel_b,
	input wire        serial_in_line,
	input wire        serial_out,
	input wire        serial_out_en,
	// Status
	input wire        wel_set,
	input wire [2:0]  secreg_otp_lock_bits,
	input wire        write_protect_select,
	input wire        write_enable_latch,
	input wire        busy,
	// Protection query
	input wire [23:0] prot_addr,
	input wire        legacy_range_protect,
	input wire        array_protected
);
	default clocking cb @(posedge mclk); endclocking
	default disable iff (!rst_b);
	////////////////////////////////////////////////////////////////
	property p_wel; $past(rst_b,3) && wel_set |=> write_enable_latch; endproperty
	a_wel: assert property (p_wel) else $error("latch not set");
	property p_wel_hold; !wel_set && !write_enable_latch |=> !write_enable_latch; endproperty
	a_wel_hold: assert property (p_wel_hold) else $error("latch set unasked");
	property p_wel_clr; $fell(busy) |-> !write_enable_latch; endproperty
	a_wel_clr: assert property (p_wel_clr) else $error("latch kept");
	property p_busy_cause; $rose(busy) |-> chip_sel_b; endproperty
	a_busy_cause: assert property (p_busy_cause) else $error("busy in frame");
	property p_busy_min; $rose(busy) |-> busy[*8]; endproperty
	a_busy_min: assert property (p_busy_min) else $error("busy short");
	property p_busy_max; $rose(busy) |-> ##[1:800] !busy; endproperty
	a_busy_max: assert property (p_busy_max) else $error("busy stuck");
	property p_prot; $past(rst_b,3) && !write_protect_select |=> array_protected == $past(legacy_range_protect);
	endproperty
	a_prot: assert property (p_prot) else $error("legacy not used");
	property p_en_off; chip_sel_b[*5] |-> !serial_out_en; endproperty
	a_en_off: assert property (p_en_off) else $error("drive after frame");
	// Output may only move after a link clock fall
	property p_out_fall; $changed(serial_out) && serial_out_en |-> !$past(spi_clk,2); endproperty
	a_out_fall: assert property (p_out_fall) else $error("out moved on rise");
endmodule // fsl_chk

// *** verification/fsl_host.sv ***
// Host link model driving select, clock and data
`timescale 1ns/1ps
module fsl_host (
	// Clock
	input wire  mclk,
	// Link
	output logic spi_clk,
	output logic chip_sel_b,
	output logic serial_in_line,
	input wire  serial_out
);
	initial begin
		spi_clk = 1'b0;
		chip_sel_b = 1'b1;
		serial_in_line = 1'b0;
	end
	////////////////////////////////////////////////////////////////
	// Select held low over the whole frame; n bits MSB first
	task frame(input logic [63:0] t, input int n, output logic [15:0] r);
		r = 16'h0;
		@(posedge mclk) chip_sel_b <= 1'b0;
		repeat (4) @(posedge mclk);
		for (int i = 0; i < n; i++) begin
			serial_in_line <= t[63-i];
			repeat (4) @(posedge mclk);
			spi_clk <= 1'b1;
			repeat (4) @(posedge mclk);
			r = {r[14:0], serial_out};
			spi_clk <= 1'b0;
		end
		// Select rises right after the last bit
		repeat (4) @(posedge mclk);
		chip_sel_b <= 1'b1;
		serial_in_line <= ~serial_in_line;
		repeat (6) @(posedge mclk);
	endtask
endmodule // fsl_host

// *** verification/test_flash_secreg_sfdp_lock_cmds.sv ***
// Testbench for the command handler
`timescale 1ns/1ps
module test_flash_secreg_sfdp_lock_cmds;
	logic        mclk = 1'b0;
	logic        rst_b = 1'b0;
	logic        wel_set = 1'b0;
	logic        write_protect_select = 1'b0;
	logic        legacy_range_protect = 1'b0;
	logic [2:0]  secreg_otp_lock_bits = 3'h0;
	logic [23:0] prot_addr = 24'h0;
	int          en_seen = 0;
	int          en_mark = 0;
	logic [15:0] q;
	wire         spi_clk, chip_sel_b, serial_in_line, serial_out;
	wire         serial_out_en, write_enable_latch, busy, array_protected;
	int          errors = 0;
	int          checks_done = 0;
	initial forever #5 mclk = ~mclk;
	always @(posedge mclk) if (serial_out_en === 1'b1) en_seen <= en_seen + 1;
	// Short cycle counts keep the run brief
	fsl_cmd #(.ERASE_CYCLES(24'd20), .PROG_CYCLES(24'd10)) dut_u (.mclk, .rst_b, .spi_clk, .chip_sel_b,
		.serial_in_line, .serial_out, .serial_out_en, .wel_set, .secreg_otp_lock_bits, .write_protect_select,
		.write_enable_latch, .busy, .prot_addr, .legacy_range_protect, .array_protected);
	fsl_host host_u (.mclk, .spi_clk, .chip_sel_b, .serial_in_line, .serial_out);
	////////////////////////////////////////////////////////////////
	task chk(input logic [15:0] g, input logic [15:0] e);
		checks_done++;
		if (g !== e) begin
			errors++;
			$display("wrong value at %0t: got %h expected %h", $time, g, e);
		end
	endtask
	task fr(input logic [7:0] op, input logic [23:0] a, input logic [7:0] d, input int n);
		host_u.frame({op, a, d, 24'h0}, n, q);
	endtask
	task arm;
		@(posedge mclk) wel_set <= 1'b1;
		@(posedge mclk) wel_set <= 1'b0;
	endtask
	task idle;
		int k;
		k = 0;
		repeat (5) @(posedge mclk);
		while (busy !== 1'b0 && k < 3000) begin
			@(posedge mclk);
			k++;
		end
		chk(16'(busy), 16'h0);
	endtask
	task prot(input logic [23:0] a, input logic e);
		@(posedge mclk) prot_addr <= a;
		repeat (3) @(posedge mclk);
		chk(16'(array_protected), 16'(e));
	endtask
	task wrap_up;
		$display("checks %0d, mismatches %0d", checks_done, errors);
		if (errors == 0 && checks_done > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask
	////////////////////////////////////////////////////////////////
	initial begin
		repeat (10) @(posedge mclk);
		rst_b <= 1'b1;
		repeat (4) @(posedge mclk);
		chk(16'({write_enable_latch, busy}), 16'h0);
		fr(8'h5a, 24'h0, 8'h0, 56);
		chk(q, 16'h5346);
		fr(8'h5a, 24'hff, 8'h0, 56);
		chk(q, 16'hff53);
		$display("table read test over");
		write_protect_select <= 1'b1;
		prot(24'h040000, 1'b1);
		fr(8'h3d, 24'h040000, 8'h0, 40);
		chk(16'(q[0]), 16'h1);
		fr(8'h39, 24'h040000, 8'h0, 32);
		prot(24'h040000, 1'b1);
		arm;
		fr(8'h39, 24'h040000, 8'h0, 32);
		prot(24'h040000, 1'b0);
		fr(8'h3d, 24'h040000, 8'h0, 40);
		chk(16'(q[0]), 16'h0);
		arm;
		fr(8'h36, 24'h040000, 8'h0, 32);
		prot(24'h040000, 1'b1);
		write_protect_select <= 1'b0;
		prot(24'h040000, 1'b0);
		$display("block lock test over");
		fr(8'h44, 24'h001000, 8'h0, 32);
		chk(16'(busy), 16'h0);
		arm;
		fr(8'h44, 24'h001000, 8'h0, 33);
		chk(16'(busy), 16'h0);
		fr(8'h44, 24'h001000, 8'h0, 32);
		chk(16'(busy), 16'h1);
		idle;
		chk(16'(write_enable_latch), 16'h0);
		fr(8'h48, 24'h001000, 8'h0, 56);
		chk(q, 16'hffff);
		arm;
		fr(8'h42, 24'h001000, 8'ha5, 40);
		idle;
		fr(8'h48, 24'h001000, 8'h0, 56);
		chk(q, 16'ha5ff);
		fr(8'h48, 24'h0010ff, 8'h0, 56);
		chk(q, 16'hffa5);
		$display("erase and program test over");
		secreg_otp_lock_bits <= 3'h1;
		arm;
		fr(8'h44, 24'h001000, 8'h0, 32);
		chk(16'(busy), 16'h0);
		fr(8'h42, 24'h001001, 8'h00, 40);
		chk(16'(busy), 16'h0);
		fr(8'h48, 24'h001000, 8'h0, 56);
		chk(q, 16'ha5ff);
		fr(8'h44, 24'h004000, 8'h0, 32);
		chk(16'(busy), 16'h0);
		secreg_otp_lock_bits <= 3'h0;
		arm;
		fr(8'h44, 24'h002000, 8'h0, 32);
		chk(16'(busy), 16'h1);
		en_mark = en_seen;
		fr(8'h48, 24'h002000, 8'h0, 56);
		chk(16'(en_seen - en_mark), 16'h0);
		idle;
		arm;
		fr(8'h42, 24'h002000, 8'h3c, 40);
		idle;
		fr(8'h48, 24'h002000, 8'h0, 56);
		chk(q, 16'h3cff);
		$display("otp lock and busy test over");
		wrap_up;
	end
	// Whole run needs well under this span
	initial begin
		repeat (60000) @(posedge mclk);
		errors++;
		$display("watchdog expired");
		wrap_up;
	end
endmodule // test_flash_secreg_sfdp_lock_cmds
bind fsl_cmd fsl_chk #(
	.ERASE_CYCLES(ERASE_CYCLES),
	.PROG_CYCLES (PROG_CYCLES)
) chk_u (
	.mclk                 (mclk),
	.rst_b                (rst_b),
	.spi_clk              (spi_clk),
	.chip_sel_b           (chip_sel_b),
	.serial_in_line       (serial_in_line),
	.serial_out           (serial_out),
	.serial_out_en        (serial_out_en),
	.wel_set              (wel_set),
	.secreg_otp_lock_bits (secreg_otp_lock_bits),
	.write_protect_select (write_protect_select),
	.write_enable_latch   (write_enable_latch),
	.busy                 (busy),
	.prot_addr            (prot_addr),
	.legacy_range_protect (legacy_range_protect),
	.array_protected      (array_protected)
);
